// ---- core/cit_consts.svh ----
// timing counts, opcode patterns and reset values for the instruction timing block
`ifndef CIT_CONSTS_SVH
`define CIT_CONSTS_SVH

// ****************************************************************
// clock and timing figures
// ****************************************************************
`define CIT_CLK_MHZ 40
`define CIT_MAX_CLK_MHZ 48
`define CIT_CYC_W 4
`define CIT_MAX_CYCLES 4'h8
`define CIT_MUL_CYCLES 4'h4
`define CIT_DIV_CYCLES 4'h8
`define CIT_ONE_CYCLE 4'h1
`define CIT_TWO_CYCLES 4'h2
`define CIT_THREE_CYCLES 4'h3

// ****************************************************************
// byte counts
// ****************************************************************
`define CIT_BYTES_W 2
`define CIT_ONE_BYTE 2'h1
`define CIT_TWO_BYTES 2'h2
`define CIT_THREE_BYTES 2'h3

// ****************************************************************
// opcode rows (upper nibble) and column fields (lower nibble)
// ****************************************************************
`define CIT_ROW_INC 4'h0
`define CIT_ROW_DEC 4'h1
`define CIT_ROW_ADD 4'h2
`define CIT_ROW_ADDC 4'h3
`define CIT_ROW_ORL 4'h4
`define CIT_ROW_ANL 4'h5
`define CIT_ROW_SUBB 4'h9
`define CIT_COL_IMM 4'h4
`define CIT_COL_DIR 4'h5
`define CIT_COL_IND 3'h3
`define CIT_COL_DIR_A 4'h2
`define CIT_COL_DIR_IMM 4'h3
`define CIT_COL_BIT_BR 4'h0
`define CIT_OP_JBC 8'h10
`define CIT_OP_JB 8'h20
`define CIT_OP_JNB 8'h30
`define CIT_OP_JC 8'h40
`define CIT_OP_JNC 8'h50
`define CIT_OP_INC_DPTR 8'ha3
`define CIT_OP_MUL 8'ha4
`define CIT_OP_DIV 8'h84
`define CIT_OP_DA 8'hd4

// ****************************************************************
// reset values and debug sizing
// ****************************************************************
`define CIT_RST_BYTE 8'h00
`define CIT_RST_CNT 4'h0
`define CIT_NUM_BP 4
`define CIT_PC_W 16

`endif

// ---- core/cit_pkg.sv ----
// types shared by the instruction timing block
package cit_pkg;

    typedef enum logic [3:0] {
        CIT_ALU_NONE = 4'h0,
        CIT_ALU_ADD = 4'h1,
        CIT_ALU_ADDC = 4'h2,
        CIT_ALU_SUBB = 4'h3,
        CIT_ALU_INC = 4'h4,
        CIT_ALU_DEC = 4'h5,
        CIT_ALU_AND = 4'h6,
        CIT_ALU_OR = 4'h7,
        CIT_ALU_MUL = 4'h8,
        CIT_ALU_DIV = 4'h9,
        CIT_ALU_DA = 4'ha
    } cit_alu_op_t;

    // gray along idle -> exec -> halt
    typedef enum logic [1:0] {
        CIT_ST_IDLE = 2'b00,
        CIT_ST_EXEC = 2'b01,
        CIT_ST_HALT = 2'b11
    } cit_state_t;

    typedef struct packed {
        logic cy;
        logic ac;
        logic ov;
    } cit_flags_t;

    typedef struct packed {
        logic [1:0] bytes;
        logic [3:0] cycles;
        logic [3:0] cycles_taken;
        logic is_cond_branch;
        cit_alu_op_t alu_op;
    } cit_dec_t;

endpackage

// ---- core/cit_opdec.sv ----
// opcode to byte count, cycle count and operation class
`timescale 1ns/1ps
`include "cit_consts.svh"

module cit_opdec
    import cit_pkg::*;
(
    input wire logic [7:0] opcode,
    output cit_dec_t dec
);

    wire [3:0] row = opcode[7:4];
    wire [3:0] col = opcode[3:0];

    // ****************************************************************
    // column decode for the regular arithmetic and logic rows
    // ****************************************************************
    wire col_rn = opcode[3];
    wire col_ind = (opcode[3:1] == `CIT_COL_IND);
    wire col_dir = (col == `CIT_COL_DIR);
    wire col_imm = (col == `CIT_COL_IMM);
    wire col_reg = col_rn | col_ind | col_dir | col_imm;

    wire row_incdec = (row == `CIT_ROW_INC) | (row == `CIT_ROW_DEC);
    wire row_logic = (row == `CIT_ROW_ORL) | (row == `CIT_ROW_ANL);
    wire row_arith = row_incdec | row_logic | (row == `CIT_ROW_ADD) | (row == `CIT_ROW_ADDC) |
                     (row == `CIT_ROW_SUBB);
    wire is_regular = row_arith & col_reg;
    wire is_logic_dir_a = row_logic & (col == `CIT_COL_DIR_A);
    wire is_logic_dir_imm = row_logic & (col == `CIT_COL_DIR_IMM);

    // ****************************************************************
    // conditional branches
    // ****************************************************************
    wire is_bit_br = (opcode == `CIT_OP_JBC) | (opcode == `CIT_OP_JB) | (opcode == `CIT_OP_JNB);
    wire is_cy_br = (opcode == `CIT_OP_JC) | (opcode == `CIT_OP_JNC);
    wire is_cond_br = is_bit_br | is_cy_br;

    // ****************************************************************
    // byte and cycle figures
    // ****************************************************************
    // the one-byte form in the immediate column of inc/dec works on the accumulator
    wire acc_form = row_incdec & col_imm;
    wire two_byte = (is_regular & (col_dir | (col_imm & ~acc_form))) | is_logic_dir_a | is_cy_br;
    wire three_byte = is_logic_dir_imm | is_bit_br;

    wire [1:0] bytes_w = three_byte ? `CIT_THREE_BYTES : two_byte ? `CIT_TWO_BYTES : `CIT_ONE_BYTE;

    // most instructions take one cycle per byte; indirect forms and mul/div do not
    wire [3:0] cycles_w = (opcode == `CIT_OP_DIV) ? `CIT_DIV_CYCLES :
                          (opcode == `CIT_OP_MUL) ? `CIT_MUL_CYCLES :
                          three_byte ? `CIT_THREE_CYCLES :
                          (two_byte | (is_regular & col_ind)) ? `CIT_TWO_CYCLES : `CIT_ONE_CYCLE;

    // a taken branch spends one cycle more than the not-taken case
    wire [3:0] taken_w = is_cond_br ? 4'(cycles_w + `CIT_ONE_CYCLE) : cycles_w;

    // ****************************************************************
    // operation class for the flag unit
    // ****************************************************************
    cit_alu_op_t alu_w;
    assign alu_w = (opcode == `CIT_OP_MUL) ? CIT_ALU_MUL :
                   (opcode == `CIT_OP_DIV) ? CIT_ALU_DIV :
                   (opcode == `CIT_OP_DA) ? CIT_ALU_DA :
                   ~is_regular ? CIT_ALU_NONE :
                   (row == `CIT_ROW_INC) ? CIT_ALU_INC :
                   (row == `CIT_ROW_DEC) ? CIT_ALU_DEC :
                   (row == `CIT_ROW_ADD) ? CIT_ALU_ADD :
                   (row == `CIT_ROW_ADDC) ? CIT_ALU_ADDC :
                   (row == `CIT_ROW_SUBB) ? CIT_ALU_SUBB :
                   (row == `CIT_ROW_ANL) ? CIT_ALU_AND : CIT_ALU_OR;

    assign dec.bytes = bytes_w;
    assign dec.cycles = cycles_w;
    assign dec.cycles_taken = taken_w;
    assign dec.is_cond_branch = is_cond_br;
    assign dec.alu_op = alu_w;

endmodule

// ---- core/cit_dbg.sv ----
// debug run control: breakpoints, halt, run and single step
`timescale 1ns/1ps
`include "cit_consts.svh"

module cit_dbg
    import cit_pkg::*;
#(
    parameter int NUM_BP = `CIT_NUM_BP,
    parameter int SEL_W = 2
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [15:0] pc,
    input wire logic opcode_valid,
    input wire logic issue,
    input wire logic halt_req,
    input wire logic run_req,
    input wire logic step_req,
    input wire logic bp_wr,
    input wire logic [SEL_W-1:0] bp_sel,
    input wire logic [15:0] bp_addr,
    input wire logic bp_en,
    output logic issue_ok,
    output logic halt_next,
    output logic halted
);

    logic [NUM_BP-1:0] hit;
    logic halted_reg;
    logic step_reg;
    logic skip_bp_reg;

    // ****************************************************************
    // breakpoint comparators, held in flops beside the core
    // ****************************************************************
    // dedicated flops so that no user ram, stack or timer is borrowed [RQ14]
    for (genvar i = 0; i < NUM_BP; i++) begin : g_bp
        logic [15:0] addr_reg;
        logic en_reg;
        wire sel = bp_wr & (bp_sel == SEL_W'(i));
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                addr_reg <= 16'h0000;
                en_reg <= 1'b0;
            end else if (sel) begin
                addr_reg <= bp_addr;
                en_reg <= bp_en;
            end
        end
        assign hit[i] = en_reg & opcode_valid & (addr_reg == pc);
    end

    // ****************************************************************
    // run control
    // ****************************************************************
    // the first instruction after a resume ignores its own breakpoint, else it could never leave it
    wire bp_stop = (|hit) & ~skip_bp_reg;
    wire resume = halted_reg & (run_req | step_req);

    assign issue_ok = ~halted_reg & ~bp_stop;
    // a step lets exactly one instruction issue, wherever it lies, handlers included [RQ14]
    assign halt_next = halted_reg ? ~resume : (halt_req | bp_stop | (step_reg & issue));
    assign halted = halted_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            halted_reg <= 1'b0;
            step_reg <= 1'b0;
            skip_bp_reg <= 1'b0;
        end else begin
            halted_reg <= halt_next;
            step_reg <= resume ? step_req : (step_reg & ~issue);
            skip_bp_reg <= resume ? 1'b1 : (skip_bp_reg & ~issue);
        end
    end

endmodule

// ---- core/cit_core_timing.sv ----
// instruction issue and cycle timing with flag unit and debug run control
//
// Summary of operation
// [RQ1] timing counted in plain clock cycles only
// [RQ2] most instructions: cycles equal program bytes
// [RQ3] untaken conditional branch one cycle shorter
// [RQ4] no instruction exceeds eight cycles
// [RQ5] up to 48 MHz, one instruction per clock
// [RQ6] encodings and flag effects match standard set
// [RQ7] register and accumulator arithmetic: one byte, one cycle
// [RQ8] direct byte arithmetic: two bytes, two cycles
// [RQ9] indirect arithmetic: one byte, two cycles
// [RQ10] immediate arithmetic: two bytes, two cycles
// [RQ11] and register one cycle, indirect two
// [RQ12] and into direct byte: two bytes, two cycles
// [RQ13] and immediate into direct: three bytes, three
// [RQ14] debug: breakpoints, run, stop, step, access
// [RQ15] multiply four cycles, divide eight cycles
`timescale 1ns/1ps
`include "cit_consts.svh"

module cit_core_timing
    import cit_pkg::*;
#(
    parameter int NUM_BP = `CIT_NUM_BP
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [7:0] OPCODE,
    input wire logic OPCODE_VALID,
    input wire logic [15:0] OPCODE_PC,
    input wire logic COND_TRUE,
    input wire logic [7:0] ACC_IN,
    input wire logic [7:0] B_IN,
    input wire logic [7:0] OPND_IN,
    input cit_flags_t FLAGS_IN,
    input wire logic DBG_HALT_REQ,
    input wire logic DBG_RUN_REQ,
    input wire logic DBG_STEP_REQ,
    input wire logic DBG_BP_WR,
    input wire logic [1:0] DBG_BP_SEL,
    input wire logic [15:0] DBG_BP_ADDR,
    input wire logic DBG_BP_EN,
    input wire logic DBG_ACC_REQ,
    output logic OPCODE_READY,
    output logic INSN_DONE,
    output logic [1:0] INSN_BYTES,
    output logic [3:0] INSN_CYCLES,
    output logic [7:0] RESULT_A,
    output logic [7:0] RESULT_B,
    output cit_flags_t FLAGS_OUT,
    output logic DBG_HALTED,
    output logic DBG_ACC_GRANT
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    cit_dec_t dec;
    cit_state_t state_reg;
    cit_state_t state_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic ready_reg;
    logic ready_next;
    logic done_reg;
    logic done_next;
    logic [1:0] bytes_reg;
    logic [3:0] cycles_reg;
    logic [7:0] res_a_reg;
    logic [7:0] res_b_reg;
    cit_flags_t flags_reg;
    logic grant_reg;
    logic issue;
    logic issue_ok;
    logic halt_next;
    logic halted;
    logic [7:0] alu_a;
    logic [7:0] alu_b;
    cit_flags_t alu_f;

    // ****************************************************************
    // opcode decode and debug control
    // ****************************************************************
    cit_opdec u_opdec (
        .opcode(OPCODE),
        .dec(dec)
    );

    cit_dbg #(
        .NUM_BP(NUM_BP),
        .SEL_W(2)
    ) u_dbg (
        .clk(CLK),
        .rst_b(RST_B),
        .pc(OPCODE_PC),
        .opcode_valid(OPCODE_VALID),
        .issue(issue),
        .halt_req(DBG_HALT_REQ),
        .run_req(DBG_RUN_REQ),
        .step_req(DBG_STEP_REQ),
        .bp_wr(DBG_BP_WR),
        .bp_sel(DBG_BP_SEL),
        .bp_addr(DBG_BP_ADDR),
        .bp_en(DBG_BP_EN),
        .issue_ok(issue_ok),
        .halt_next(halt_next),
        .halted(halted)
    );

    // ****************************************************************
    // issue and cycle selection
    // ****************************************************************
    // an opcode is accepted in the very cycle the previous one ends, so one-cycle
    // instructions retire back to back at the full clock rate [RQ5]
    assign issue = OPCODE_VALID & ready_reg & issue_ok;

    // the condition is settled by the datapath in the issue cycle [RQ3]
    wire [3:0] raw_cycles = (dec.is_cond_branch & COND_TRUE) ? dec.cycles_taken : dec.cycles;

    // hard ceiling on any sequence length; the table never exceeds it [RQ4]
    wire [3:0] sel_cycles = (raw_cycles > `CIT_MAX_CYCLES) ? `CIT_MAX_CYCLES : raw_cycles;

    // counting is on every clock edge; there is no multi-clock machine cycle [RQ1]
    wire [3:0] load_cnt = 4'(sel_cycles - `CIT_ONE_CYCLE);
    wire last_of_busy = (cnt_reg == `CIT_ONE_CYCLE);

    // ****************************************************************
    // next-state decode
    // ****************************************************************
    always_comb begin
        cnt_next = cnt_reg;
        state_next = state_reg;
        done_next = 1'b0;
        case (state_reg)
            CIT_ST_IDLE: begin
                if (issue) begin
                    cnt_next = load_cnt;
                    done_next = (sel_cycles == `CIT_ONE_CYCLE);
                    state_next = (sel_cycles == `CIT_ONE_CYCLE) ? CIT_ST_IDLE : CIT_ST_EXEC;
                end
                if (halt_next) begin
                    state_next = (sel_cycles == `CIT_ONE_CYCLE || !issue) ? CIT_ST_HALT : CIT_ST_EXEC;
                end
            end
            CIT_ST_EXEC: begin
                cnt_next = 4'(cnt_reg - `CIT_ONE_CYCLE);
                done_next = last_of_busy;
                if (last_of_busy) begin
                    state_next = halt_next ? CIT_ST_HALT : CIT_ST_IDLE;
                end
            end
            CIT_ST_HALT: begin
                state_next = halt_next ? CIT_ST_HALT : CIT_ST_IDLE;
            end
            default: begin
                cnt_next = `CIT_RST_CNT;
                state_next = CIT_ST_IDLE;
            end
        endcase
    end

    // ready when the pipe is free next cycle and debug has not stopped the core
    assign ready_next = (state_next == CIT_ST_IDLE);

    // ****************************************************************
    // flag unit, same encodings and flag effects as the standard set
    // ****************************************************************
    always_comb begin
        logic [8:0] sum9;
        logic [4:0] nib5;
        logic [15:0] prod;
        logic [7:0] da_v;
        logic da_cy;
        sum9 = 9'h000;
        nib5 = 5'h00;
        prod = 16'h0000;
        da_v = ACC_IN;
        da_cy = FLAGS_IN.cy;
        alu_a = ACC_IN;
        alu_b = B_IN;
        alu_f = FLAGS_IN;
        case (dec.alu_op)
            CIT_ALU_ADD, CIT_ALU_ADDC: begin
                sum9 = {1'b0, ACC_IN} + {1'b0, OPND_IN} + {8'h00, (dec.alu_op == CIT_ALU_ADDC) & FLAGS_IN.cy};
                nib5 = {1'b0, ACC_IN[3:0]} + {1'b0, OPND_IN[3:0]} +
                       {4'h0, (dec.alu_op == CIT_ALU_ADDC) & FLAGS_IN.cy};
                alu_a = sum9[7:0];
                alu_f.cy = sum9[8];
                alu_f.ac = nib5[4];
                alu_f.ov = (ACC_IN[7] == OPND_IN[7]) & (sum9[7] != ACC_IN[7]); // [RQ6]
            end
            CIT_ALU_SUBB: begin
                sum9 = {1'b0, ACC_IN} - {1'b0, OPND_IN} - {8'h00, FLAGS_IN.cy};
                nib5 = {1'b0, ACC_IN[3:0]} - {1'b0, OPND_IN[3:0]} - {4'h0, FLAGS_IN.cy};
                alu_a = sum9[7:0];
                alu_f.cy = sum9[8];
                alu_f.ac = nib5[4];
                alu_f.ov = (ACC_IN[7] != OPND_IN[7]) & (sum9[7] != ACC_IN[7]); // [RQ6]
            end
            // inc and dec leave every flag alone
            CIT_ALU_INC: alu_a = 8'(OPND_IN + 8'h01);
            CIT_ALU_DEC: alu_a = 8'(OPND_IN - 8'h01);
            CIT_ALU_AND: alu_a = ACC_IN & OPND_IN;
            CIT_ALU_OR: alu_a = ACC_IN | OPND_IN;
            CIT_ALU_MUL: begin
                prod = ACC_IN * B_IN;
                alu_a = prod[7:0];
                alu_b = prod[15:8];
                alu_f.cy = 1'b0;
                alu_f.ov = (prod[15:8] != 8'h00); // [RQ6]
            end
            CIT_ALU_DIV: begin
                // divide by zero keeps the operands and raises overflow
                alu_f.cy = 1'b0;
                alu_f.ov = (B_IN == 8'h00); // [RQ6]
                if (B_IN != 8'h00) begin
                    alu_a = ACC_IN / B_IN;
                    alu_b = ACC_IN % B_IN;
                end
            end
            CIT_ALU_DA: begin
                if (ACC_IN[3:0] > 4'h9 || FLAGS_IN.ac) begin
                    {da_cy, da_v} = {1'b0, da_v} + 9'h006 | {FLAGS_IN.cy, 8'h00};
                end
                if (da_v[7:4] > 4'h9 || da_cy) begin
                    {da_cy, da_v} = {1'b0, da_v} + 9'h060 | {da_cy, 8'h00};
                end
                alu_a = da_v;
                alu_f.cy = da_cy;
            end
            default: begin
                alu_a = ACC_IN;
            end
        endcase
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg <= CIT_ST_IDLE;
            cnt_reg <= `CIT_RST_CNT;
            ready_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            ready_reg <= ready_next;
            done_reg <= done_next; // [RQ2] [RQ7] [RQ8] [RQ9] [RQ10] [RQ11] [RQ12] [RQ13] [RQ15]
        end
    end

    // the figures and results of the issued instruction hold until the next issue
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            bytes_reg <= 2'h0;
            cycles_reg <= `CIT_RST_CNT;
            res_a_reg <= `CIT_RST_BYTE;
            res_b_reg <= `CIT_RST_BYTE;
            flags_reg <= '0;
        end else if (issue) begin
            bytes_reg <= dec.bytes;
            cycles_reg <= sel_cycles; // [RQ3] [RQ4]
            res_a_reg <= alu_a;
            res_b_reg <= alu_b;
            flags_reg <= alu_f;
        end
    end

    // memory and register access by the debug host only while the core is stopped
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            grant_reg <= 1'b0;
        end else begin
            grant_reg <= DBG_ACC_REQ & halted & (state_reg == CIT_ST_HALT); // [RQ14]
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign OPCODE_READY = ready_reg;
    assign INSN_DONE = done_reg;
    assign INSN_BYTES = bytes_reg;
    assign INSN_CYCLES = cycles_reg;
    assign RESULT_A = res_a_reg;
    assign RESULT_B = res_b_reg;
    assign FLAGS_OUT = flags_reg;
    assign DBG_HALTED = halted;
    assign DBG_ACC_GRANT = grant_reg;

endmodule

// ---- verification/cit_core_timing_monitor.sv ----
// concurrent checks on the ports of the instruction timing block
`timescale 1ns/1ps
module cit_core_timing_monitor (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [7:0] OPCODE,
    input wire logic OPCODE_VALID,
    input wire logic COND_TRUE,
    input wire logic DBG_HALT_REQ,
    input wire logic DBG_RUN_REQ,
    input wire logic DBG_STEP_REQ,
    input wire logic DBG_ACC_REQ,
    input wire logic OPCODE_READY,
    input wire logic INSN_DONE,
    input wire logic [1:0] INSN_BYTES,
    input wire logic [3:0] INSN_CYCLES,
    input wire logic DBG_HALTED,
    input wire logic DBG_ACC_GRANT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    wire iss = OPCODE_VALID && OPCODE_READY && !DBG_HALTED;
    logic [3:0] age_reg;
    // saturates so that a long halt cannot wrap back to a small count
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            age_reg <= 4'h0;
        end else if (iss) begin
            age_reg <= 4'h1;
        end else if (age_reg != 4'hf) begin
            age_reg <= age_reg + 4'h1;
        end
    end
    property p_done_age; INSN_DONE |-> age_reg == INSN_CYCLES; endproperty
    a_done_age: assert property (p_done_age) else $error("done at wrong cycle");
    property p_max; INSN_DONE |-> INSN_CYCLES != 4'h0 && INSN_CYCLES <= 4'h8; endproperty
    a_max: assert property (p_max) else $error("cycle count out of range");
    property p_add; iss && OPCODE == 8'h28 ##1 !DBG_HALTED
        |-> INSN_DONE && OPCODE_READY && INSN_BYTES == 2'h1 && INSN_CYCLES == 4'h1; endproperty
    a_add: assert property (p_add) else $error("register add timing");
    property p_ind; iss && OPCODE == 8'h26 ##1 !DBG_HALTED |-> !OPCODE_READY && INSN_CYCLES == 4'h2 ##1 INSN_DONE;
    endproperty
    a_ind: assert property (p_ind) else $error("indirect add timing");
    property p_anl3; iss && OPCODE == 8'h53 ##1 !DBG_HALTED
        |-> INSN_BYTES == 2'h3 && !OPCODE_READY ##1 !OPCODE_READY ##1 INSN_DONE; endproperty
    a_anl3: assert property (p_anl3) else $error("and immediate to direct timing");
    property p_mul; iss && OPCODE == 8'ha4 ##1 !DBG_HALTED |-> !OPCODE_READY [*3] ##1 INSN_DONE; endproperty
    a_mul: assert property (p_mul) else $error("multiply timing");
    property p_branch; iss && OPCODE == 8'h40 ##1 !DBG_HALTED
        |-> INSN_CYCLES == ($past(COND_TRUE) ? 4'h3 : 4'h2); endproperty
    a_branch: assert property (p_branch) else $error("branch timing");
    property p_halt; DBG_HALT_REQ |=> DBG_HALTED; endproperty
    a_halt: assert property (p_halt) else $error("stop not taken");
    property p_resume; DBG_HALTED && !DBG_HALT_REQ && (DBG_RUN_REQ || DBG_STEP_REQ) |=> !DBG_HALTED; endproperty
    a_resume: assert property (p_resume) else $error("resume not taken");
    property p_grant; DBG_HALTED && DBG_ACC_REQ ##1 DBG_HALTED |-> DBG_ACC_GRANT; endproperty
    a_grant: assert property (p_grant) else $error("access not granted");
endmodule
bind cit_core_timing cit_core_timing_monitor mon (.CLK(CLK), .RST_B(RST_B), .OPCODE(OPCODE),
    .OPCODE_VALID(OPCODE_VALID), .COND_TRUE(COND_TRUE), .DBG_HALT_REQ(DBG_HALT_REQ), .DBG_RUN_REQ(DBG_RUN_REQ),
    .DBG_STEP_REQ(DBG_STEP_REQ), .DBG_ACC_REQ(DBG_ACC_REQ), .OPCODE_READY(OPCODE_READY), .INSN_DONE(INSN_DONE),
    .INSN_BYTES(INSN_BYTES), .INSN_CYCLES(INSN_CYCLES), .DBG_HALTED(DBG_HALTED), .DBG_ACC_GRANT(DBG_ACC_GRANT));

// ---- verification/cit_pmem.sv ----
// program memory model that offers one opcode per entry to the timing block
`timescale 1ns/1ps
module cit_pmem (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic en,
    input wire logic ready,
    input wire logic halted,
    output logic [7:0] opcode,
    output logic valid,
    output logic [15:0] pc,
    output logic cond
);
    logic [8:0] rom [15];
    logic [3:0] pc_reg;
    assign valid = en && (pc_reg != 4'hf);
    // an idle bus shows the inverse of the entry, never a stale opcode
    assign opcode = valid ? rom[pc_reg][7:0] : ~rom[pc_reg][7:0];
    assign cond = valid ? rom[pc_reg][8] : 1'b0;
    assign pc = {12'h000, pc_reg};
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_reg <= 4'h0;
        end else if (!en) begin
            pc_reg <= 4'h0;
        end else if (valid && ready && !halted) begin
            pc_reg <= pc_reg + 4'h1;
        end
    end
endmodule

// ---- verification/test_cit_core_timing.sv ----
// self-checking bench for the instruction timing block
`timescale 1ns/1ps
module test_cit_core_timing;
    import cit_pkg::*;
    logic CLK, RST_B, en, hreq, rreq, sreq, areq, cnd, vld, rdy, done, halted, grant, bwr;
    logic [3:0] cyc;
    logic [7:0] op, acc, b, opnd, ra, rb;
    logic [15:0] pc, baddr;
    logic [1:0] bytes, bsel;
    cit_flags_t fin, fout;
    int n_mismatch = 0;
    int num_checks = 0;
    int n_cyc = 0;
    cit_pmem pm (.clk(CLK), .rst_b(RST_B), .en(en), .ready(rdy), .halted(halted), .opcode(op), .valid(vld),
        .pc(pc), .cond(cnd));
    cit_core_timing uut (.CLK(CLK), .RST_B(RST_B), .OPCODE(op), .OPCODE_VALID(vld), .OPCODE_PC(pc),
        .COND_TRUE(cnd), .ACC_IN(acc), .B_IN(b), .OPND_IN(opnd), .FLAGS_IN(fin), .DBG_HALT_REQ(hreq),
        .DBG_RUN_REQ(rreq), .DBG_STEP_REQ(sreq), .DBG_BP_WR(bwr), .DBG_BP_SEL(bsel), .DBG_BP_ADDR(baddr),
        .DBG_BP_EN(bwr), .DBG_ACC_REQ(areq), .OPCODE_READY(rdy), .INSN_DONE(done), .INSN_BYTES(bytes),
        .INSN_CYCLES(cyc), .RESULT_A(ra), .RESULT_B(rb), .FLAGS_OUT(fout), .DBG_HALTED(halted),
        .DBG_ACC_GRANT(grant));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // entry digits: condition, opcode (two), bytes, cycles
    task automatic run_prog(input logic [19:0] p [15]);
        int gap;
        for (int i = 0; i < 15; i++) pm.rom[i] = {p[i][16], p[i][15:8]};
        @(posedge CLK) #2;
        en = 1'b1;
        for (int i = 0; i < 15; i++) begin
            gap = 0;
            do begin
                @(posedge CLK) #2;
                gap++;
            end while (done !== 1'b1);
            check(gap, p[i][3:0]);
            check(bytes, p[i][7:4]);
            check(cyc, p[i][3:0]);
        end
        en = 1'b0;
    endtask
    task automatic count_done(input int k, output int n);
        n = 0;
        repeat (k) begin
            @(posedge CLK) #2;
            n += (done === 1'b1);
        end
    endtask
    task automatic t_classes();
        run_prog('{20'h02811, 20'h03811, 20'h09811, 20'h00411, 20'h01411,
            20'h02522, 20'h00522, 20'h02612, 20'h03422, 20'h05811,
            20'h05612, 20'h05222, 20'h05333, 20'h0a414, 20'h08418});
        check(ra, 8'h04);
        check(rb, 8'h00);
        check(fout, 3'h2);
        $display("test classes done");
    endtask
    task automatic t_branches();
        run_prog('{20'h04022, 20'h14023, 20'h15023, 20'h05022, 20'h02033,
            20'h13034, 20'h11034, 20'h01033, 20'h0a311, 20'h0d411,
            20'h00811, 20'h01811, 20'h00612, 20'h09422, 20'h02811});
        check(ra, 8'h00);
        check(fout, 3'h5);
        $display("test branches done");
    endtask
    task automatic t_debug();
        int n;
        for (int i = 0; i < 15; i++) pm.rom[i] = 9'h028;
        @(posedge CLK) #2;
        en = 1'b1;
        {bwr, bsel, baddr} = {1'b1, 2'h3, 16'h000a};
        repeat (2) @(posedge CLK);
        #2;
        hreq = 1'b1;
        bwr = 1'b0;
        @(posedge CLK) #2;
        hreq = 1'b0;
        areq = 1'b1;
        count_done(4, n);
        check(n, 0);
        check(grant, 1'b1);
        areq = 1'b0;
        sreq = 1'b1;
        @(posedge CLK) #2;
        sreq = 1'b0;
        count_done(6, n);
        check(n, 1);
        check(halted, 1'b1);
        rreq = 1'b1;
        @(posedge CLK) #2;
        rreq = 1'b0;
        count_done(4, n);
        check(n, 4);
        count_done(4, n);
        check(n, 2);
        check(halted, 1'b1);
        en = 1'b0;
        $display("test debug done");
    endtask
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    // the whole run needs about a hundred cycles
    always @(posedge CLK) begin
        n_cyc++;
        if (n_cyc == 3000) begin
            n_mismatch++;
            stop_test();
        end
    end
    initial begin
        {RST_B, en, hreq, rreq, sreq, areq, bwr} = 7'h00;
        acc = 8'h80;
        opnd = 8'h80;
        b = 8'h20;
        fin = 3'h7;
        repeat (5) @(posedge CLK);
        #2;
        RST_B = 1'b1;
        t_classes();
        t_branches();
        t_debug();
        stop_test();
    end
endmodule
